// ===== gom_top.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// RQ1: each output value bit sets its pin in push-pull, open-drain, quasi modes.
// RQ2: a zero output value drives the pin low in all three output modes.
// RQ3: a one drives high in push-pull and quasi, only releases in open-drain.
// RQ4: reset loads output values with all pin bits set: 3f, 1f, 1f, 7f.
// RQ5: pins 0-5 on a, 0-4 on b and c, 1-6 on d; rest reserved.
// RQ6: a set write-protect bit makes bus writes skip that output value bit.
// RQ7: the single-bit alias writes output values regardless of the protect bits.
// RQ8: reset clears every write-protect register.
// RQ9: mode field codes 00 input, 01 push-pull, 10 open-drain, 11 quasi.
// RQ10: a bus write merges old protected bits and new unprotected bits in one cycle.
module gom_top #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// per-pin mode from the mode select registers
	input wire logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::MODE_W-1:0] pin_mode_select,
	// single-bit alias write port
	input wire logic pin_single_bit_alias_wr,
	input wire logic [1:0] pin_single_bit_alias_port,
	input wire logic [2:0] pin_single_bit_alias_pin,
	input wire logic pin_single_bit_alias_value,
	// pads
	output logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] pin_out,
	output logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] pin_oe,
	output logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] pin_output_value
);

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("gom_top: ADDR_W must lie between 8 and 32");
		end
	endgenerate

	gom_pkg::gom_state_t st_ff;
	gom_pkg::gom_state_t nxt_st;

	logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] drv_level;
	logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] drv_enable;
	logic addr_accept;
	logic addr_hit;
	logic [1:0] addr_port;
	logic addr_is_protect;
	logic alias_hit;

	// ------------------------------------------------------------
	// pad drive, one instance per pin
	// ------------------------------------------------------------
	// pads follow the stored value one clock later, so every pad is a flop output
	generate
		for (genvar p = 0; p < gom_pkg::NUM_PORTS; p++) begin : g_port
			for (genvar n = 0; n < gom_pkg::PIN_W; n++) begin : g_pin
				gom_pin_drive u_drive (
					.pin_mode_select(pin_mode_select[p][2*n+1:2*n]),
					.pin_output_value(st_ff.out_value[p][n]),
					.implemented(gom_pkg::IMPL_PINS[p][n]),
					.drive_level(drv_level[p][n]),
					.drive_enable(drv_enable[p][n])
				);
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// address phase decode
	// ------------------------------------------------------------
	assign addr_accept = hsel && hready && (htrans == gom_pkg::HTRANS_NONSEQ || htrans == 2'b11);
	assign addr_port = haddr[gom_pkg::PORT_SEL_LSB+1:gom_pkg::PORT_SEL_LSB];
	assign addr_is_protect = (haddr[5:0] == gom_pkg::OFS_WRITE_PROTECT);
	// sub-word sizes are treated as whole-word accesses; unmapped addresses read zero
	// a shift rather than a part-select keeps the narrowest address width legal
	assign addr_hit = ((haddr >> 8) == '0)
		&& (haddr[5:0] == gom_pkg::OFS_OUTPUT_VALUE || addr_is_protect)
		&& hsize <= 3'h2;
	assign alias_hit = pin_single_bit_alias_wr
		&& gom_pkg::IMPL_PINS[pin_single_bit_alias_port][pin_single_bit_alias_pin];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [1:0] wp;
		logic [gom_pkg::PIN_W-1:0] keep;
		wp = st_ff.wr_port;
		keep = st_ff.write_protect[wp] | ~gom_pkg::IMPL_PINS[wp];
		nxt_st = st_ff;
		// data phase of a write taken in the previous cycle
		if (st_ff.wr_pend) begin
			if (st_ff.wr_is_protect) begin
				nxt_st.write_protect[wp] = hwdata[gom_pkg::PIN_W-1:0] & gom_pkg::IMPL_PINS[wp];
			end else begin
				// protected and reserved bits keep their value RQ6 RQ10 RQ5
				nxt_st.out_value[wp] = (st_ff.out_value[wp] & keep)
					| (hwdata[gom_pkg::PIN_W-1:0] & ~keep);
			end
		end
		// the alias bypasses the protect bits and wins over a bus write RQ7
		if (alias_hit) begin
			nxt_st.out_value[pin_single_bit_alias_port][pin_single_bit_alias_pin] =
				pin_single_bit_alias_value;
		end
		// address phase; read data forwards a write still in its data phase
		nxt_st.wr_pend = addr_accept && addr_hit && hwrite;
		nxt_st.wr_port = addr_port;
		nxt_st.wr_is_protect = addr_is_protect;
		nxt_st.hrdata = 32'h0000_0000;
		if (addr_accept && addr_hit && !hwrite) begin
			nxt_st.hrdata[gom_pkg::PIN_W-1:0] = addr_is_protect ?
				nxt_st.write_protect[addr_port] : nxt_st.out_value[addr_port]; // RQ5
		end
		nxt_st.hreadyout = 1'b1;
		nxt_st.pin_out = drv_level; // RQ1 RQ2 RQ9
		nxt_st.pin_oe = drv_enable;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= gom_pkg::STATE_RESET; // RQ4 RQ8
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout = st_ff.hreadyout;
	assign hresp = gom_pkg::HRESP_OKAY;
	assign hrdata = st_ff.hrdata;
	assign pin_out = st_ff.pin_out;
	assign pin_oe = st_ff.pin_oe;
	assign pin_output_value = st_ff.out_value;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic bus_value_wr;
	logic [1:0] bus_wr_port;
	assign bus_value_wr = st_ff.wr_pend && !st_ff.wr_is_protect && !pin_single_bit_alias_wr;
	assign bus_wr_port = st_ff.wr_port;

	a_reset_values: assert property (@(posedge hclk) // RQ4
		$rose(hresetn) |-> st_ff.out_value == gom_pkg::OUT_VALUE_RESET)
		else $error("output values not at reset value after reset");

	a_reset_protect: assert property (@(posedge hclk) // RQ8
		$rose(hresetn) |-> st_ff.write_protect == '0)
		else $error("write protect not cleared after reset");

	a_protect_holds: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
		bus_value_wr |=> ((st_ff.out_value[$past(bus_wr_port)]
			& $past(st_ff.write_protect[bus_wr_port]))
			== ($past(st_ff.out_value[bus_wr_port]) & $past(st_ff.write_protect[bus_wr_port]))))
		else $error("protected output bit changed on a bus write");

	a_merge_write: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
		bus_value_wr |=> ((st_ff.out_value[$past(bus_wr_port)]
			& ~$past(st_ff.write_protect[bus_wr_port]) & gom_pkg::IMPL_PINS[$past(bus_wr_port)])
			== ($past(hwdata[gom_pkg::PIN_W-1:0]) & ~$past(st_ff.write_protect[bus_wr_port])
			& gom_pkg::IMPL_PINS[$past(bus_wr_port)])))
		else $error("unprotected output bits did not take the written value");

	a_alias_bypass: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
		alias_hit |=> st_ff.out_value[$past(pin_single_bit_alias_port)][$past(pin_single_bit_alias_pin)]
			== $past(pin_single_bit_alias_value))
		else $error("alias write did not reach the output value");

	a_reserved_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
		((st_ff.pin_oe & ~gom_pkg::IMPL_PINS) == '0)
		&& st_ff.hrdata[31:gom_pkg::PIN_W] == '0)
		else $error("reserved pin driven or reserved read bits set");

	a_zero_read: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
		addr_accept && !addr_hit |=> st_ff.hrdata == 32'h0000_0000 && !st_ff.wr_pend)
		else $error("unmapped access not answered with zero");

	a_ready_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && hresp == gom_pkg::HRESP_OKAY)
		else $error("slave stalled or answered with an error");

	a_protect_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
		(st_ff.write_protect & ~gom_pkg::IMPL_PINS) == '0)
		else $error("reserved write protect bit set");

	a_value_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
		(st_ff.out_value & ~gom_pkg::IMPL_PINS)
			== (gom_pkg::OUT_VALUE_RESET & ~gom_pkg::IMPL_PINS))
		else $error("reserved output value bit changed");

	a_protect_write: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
		st_ff.wr_pend && st_ff.wr_is_protect |=> st_ff.write_protect[$past(bus_wr_port)]
			== ($past(hwdata[gom_pkg::PIN_W-1:0]) & gom_pkg::IMPL_PINS[$past(bus_wr_port)]))
		else $error("write protect register did not take the written value");

	a_value_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
		!st_ff.wr_pend && !alias_hit |=> st_ff.out_value == $past(st_ff.out_value))
		else $error("output value changed with no write");

	a_idle_read: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
		!(addr_accept && addr_hit && !hwrite) |=> st_ff.hrdata == 32'h0000_0000)
		else $error("read data not zero outside a read data phase");

	generate
		for (genvar p = 0; p < gom_pkg::NUM_PORTS; p++) begin : g_chk_port
			for (genvar n = 0; n < gom_pkg::PIN_W; n++) begin : g_chk_pin
				if (gom_pkg::IMPL_PINS[p][n]) begin : g_impl
					a_drive_low: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
						pin_mode_select[p][2*n+1:2*n] != 2'b00 && !st_ff.out_value[p][n]
						|=> st_ff.pin_oe[p][n] && !st_ff.pin_out[p][n])
						else $error("zero output value did not drive the pin low");

					a_drive_high: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
						pin_mode_select[p][2*n] && st_ff.out_value[p][n]
						|=> st_ff.pin_oe[p][n] && st_ff.pin_out[p][n])
						else $error("one did not drive high in push-pull or quasi mode");

					a_open_release: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
						pin_mode_select[p][2*n+1:2*n] == 2'b10 && st_ff.out_value[p][n]
						|=> !st_ff.pin_oe[p][n])
						else $error("open-drain pin actively driven for a one");

					a_input_float: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
						pin_mode_select[p][2*n+1:2*n] == 2'b00 |=> !st_ff.pin_oe[p][n])
						else $error("input-mode pin driven");
				end
			end
		end
	endgenerate

	c_value_write: cover property (@(posedge hclk) disable iff (!hresetn)
		bus_value_wr ##1 st_ff.out_value != $past(st_ff.out_value));

	c_protected_write: cover property (@(posedge hclk) disable iff (!hresetn)
		bus_value_wr && st_ff.write_protect[bus_wr_port] != '0);

	c_alias_under_protect: cover property (@(posedge hclk) disable iff (!hresetn)
		alias_hit && st_ff.write_protect[pin_single_bit_alias_port][pin_single_bit_alias_pin]);

	c_read_after_write: cover property (@(posedge hclk) disable iff (!hresetn)
		st_ff.wr_pend && addr_accept && addr_hit && !hwrite);

	c_refused_size: cover property (@(posedge hclk) disable iff (!hresetn)
		addr_accept && hsize > 3'h2);

endmodule

// ===== gom_pkg.sv
package gom_pkg;

	// ------------------------------------------------------------
	// port geometry
	// ------------------------------------------------------------
	localparam int NUM_PORTS = 4;
	localparam int PIN_W = 8;
	localparam int MODE_W = 2 * PIN_W;

	// ------------------------------------------------------------
	// register map: byte offsets from the block base
	// ------------------------------------------------------------
	localparam logic [7:0] PORT_A_OUTPUT_VALUE = 8'h08;
	localparam logic [7:0] PORT_A_OUTPUT_WRITE_PROTECT = 8'h0c;
	localparam logic [7:0] PORT_B_OUTPUT_VALUE = 8'h48;
	localparam logic [7:0] PORT_B_OUTPUT_WRITE_PROTECT = 8'h4c;
	localparam logic [7:0] PORT_C_OUTPUT_VALUE = 8'h88;
	localparam logic [7:0] PORT_C_OUTPUT_WRITE_PROTECT = 8'h8c;
	localparam logic [7:0] PORT_D_OUTPUT_VALUE = 8'hc8;
	localparam logic [7:0] PORT_D_OUTPUT_WRITE_PROTECT = 8'hcc;
	// port index sits in offset bits 7:6, register inside the port in bits 5:0
	localparam int PORT_SEL_LSB = 6;
	localparam logic [5:0] OFS_OUTPUT_VALUE = 6'h08;
	localparam logic [5:0] OFS_WRITE_PROTECT = 6'h0c;

	// ------------------------------------------------------------
	// implemented pins and reset values, index 0 is port a
	// ------------------------------------------------------------
	localparam logic [NUM_PORTS-1:0][PIN_W-1:0] IMPL_PINS = {8'h7e, 8'h1f, 8'h1f, 8'h3f};
	localparam logic [NUM_PORTS-1:0][PIN_W-1:0] OUT_VALUE_RESET = {8'h7f, 8'h1f, 8'h1f, 8'h3f};
	localparam logic [NUM_PORTS-1:0][PIN_W-1:0] WRITE_PROTECT_RESET = '0;

	// ------------------------------------------------------------
	// pin modes and bus encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		GOM_MODE_INPUT = 2'b00,
		GOM_MODE_PUSH_PULL = 2'b01,
		GOM_MODE_OPEN_DRAIN = 2'b10,
		GOM_MODE_QUASI = 2'b11
	} gom_mode_t;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;

	// ------------------------------------------------------------
	// state of the top module
	// ------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PORTS-1:0][PIN_W-1:0] out_value;
		logic [NUM_PORTS-1:0][PIN_W-1:0] write_protect;
		logic wr_pend;
		logic [1:0] wr_port;
		logic wr_is_protect;
		logic [31:0] hrdata;
		logic hreadyout;
		logic [NUM_PORTS-1:0][PIN_W-1:0] pin_out;
		logic [NUM_PORTS-1:0][PIN_W-1:0] pin_oe;
	} gom_state_t;

	localparam gom_state_t STATE_RESET = '{
		out_value: OUT_VALUE_RESET,
		write_protect: WRITE_PROTECT_RESET,
		wr_pend: 1'b0,
		wr_port: 2'h0,
		wr_is_protect: 1'b0,
		hrdata: 32'h0000_0000,
		hreadyout: 1'b1,
		pin_out: '0,
		pin_oe: '0
	};

endpackage

// ===== gom_pin_drive.sv
`timescale 1ns/1ps
module gom_pin_drive (
	// pin setup
	input wire logic [1:0] pin_mode_select,
	input wire logic pin_output_value,
	input wire logic implemented,
	// pad drive
	output logic drive_level,
	output logic drive_enable
);

	always_comb begin
		drive_level = 1'b0;
		drive_enable = 1'b0;
		if (implemented) begin
			unique case (gom_pkg::gom_mode_t'(pin_mode_select)) // RQ9
				gom_pkg::GOM_MODE_INPUT: begin
					drive_enable = 1'b0;
				end
				gom_pkg::GOM_MODE_PUSH_PULL, gom_pkg::GOM_MODE_QUASI: begin
					// RQ1
					drive_level = pin_output_value;
					drive_enable = 1'b1;
				end
				gom_pkg::GOM_MODE_OPEN_DRAIN: begin
					// a one only releases the pad, the pull-up is external RQ3
					drive_level = 1'b0;
					drive_enable = ~pin_output_value;
				end
			endcase
		end
	end

endmodule

// ===== gom_pad_model.sv
`timescale 1ns/1ps
module gom_pad_model (
	// pad drive from the port
	input wire logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] pin_out,
	input wire logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] pin_oe,
	// resolved pad level
	output logic [gom_pkg::NUM_PORTS-1:0][gom_pkg::PIN_W-1:0] pad_level
);
	// ------------------------------------------------------------
	// board pull-up on every pad
	// ------------------------------------------------------------
	// a released pad goes to the pull-up level, never the last driven one
	assign pad_level = (pin_oe & pin_out) | ~pin_oe;
endmodule

// ===== gom_top_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module gom_top_tb;
	// ------------------------------------------------------------
	// signals and reference model
	// ------------------------------------------------------------
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, lfsr, e, r;
	logic [3:0][15:0] mode;
	logic al_wr, al_val;
	logic [1:0] al_port;
	logic [2:0] al_pin;
	logic [3:0][7:0] pin_out, pin_oe, pov, pad_level;
	logic [7:0] ov[4], pr[4];
	logic [31:0] rdq[$];
	int n_errors, check_count, cyc;

	gom_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_mode_select(mode),
		.pin_single_bit_alias_wr(al_wr), .pin_single_bit_alias_port(al_port),
		.pin_single_bit_alias_pin(al_pin), .pin_single_bit_alias_value(al_val),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_output_value(pov));
	gom_pad_model i_pads (.pin_out(pin_out), .pin_oe(pin_oe), .pad_level(pad_level));

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	task automatic give_verdict();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// read monitor, one note per read data phase
	// ------------------------------------------------------------
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			give_verdict();
		end else begin
			if (rd_dp === 1'b1) begin
				`CHK(hreadyout, 1'b1)
				`CHK(hresp, gom_pkg::HRESP_OKAY)
				if (hreadyout === 1'b1) begin
					e = rdq.pop_front();
					`CHK(hrdata, e)
				end
			end
			if (hreadyout === 1'b1) rd_dp <= hsel && htrans[1] && !hwrite;
		end
	end

	// ------------------------------------------------------------
	// bus and pad tasks
	// ------------------------------------------------------------
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= a;
		hwrite <= wr;
		htrans <= gom_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	function automatic logic [11:0] ad(input int p, input logic prot);
		return {4'h0, p[1:0], prot ? gom_pkg::OFS_WRITE_PROTECT : gom_pkg::OFS_OUTPUT_VALUE};
	endfunction

	task automatic rd_reg(input int p, input logic prot);
		rdq.push_back({24'h0, prot ? pr[p] : ov[p]});
		bus(1'b0, ad(p, prot), 32'h0);
	endtask

	task automatic wr_reg(input int p, input logic prot, input logic [31:0] d);
		logic [7:0] im;
		im = gom_pkg::IMPL_PINS[p];
		if (prot) pr[p] = d[7:0] & im;
		else ov[p] = (ov[p] & (pr[p] | ~im)) | (d[7:0] & ~pr[p] & im);
		bus(1'b1, ad(p, prot), d);
	endtask

	task automatic chk_pads();
		logic [7:0] lv, oe;
		logic [1:0] m;
		logic im;
		repeat (3) @(posedge hclk);
		for (int p = 0; p < 4; p++) begin
			for (int n = 0; n < 8; n++) begin
				m = mode[p][2*n+:2];
				im = gom_pkg::IMPL_PINS[p][n];
				lv[n] = (im && m != 2'b00) ? ov[p][n] : 1'b1;
				oe[n] = im && (m[0] || (m == 2'b10 && !ov[p][n]));
			end
			`CHK(pad_level[p], lv)
			`CHK(pin_oe[p], oe)
			`CHK(pov[p], ov[p])
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 12'h000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		mode = '0;
		al_wr = 1'b0;
		al_port = 2'h0;
		al_pin = 3'h0;
		al_val = 1'b0;
		lfsr = 32'd94635;
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		rd_dp = 1'b0;
		for (int p = 0; p < 4; p++) begin
			ov[p] = gom_pkg::OUT_VALUE_RESET[p];
			pr[p] = 8'h00;
		end
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			rd_reg(p, 1'b0);
			rd_reg(p, 1'b1);
		end
		chk_pads();
		// unmapped places read zero and swallow writes
		rdq.push_back(32'h0);
		bus(1'b0, 12'h010, 32'h0);
		bus(1'b1, 12'h108, 32'h0);
		// sizes above a word are refused like unmapped places
		hsize <= 3'h3;
		rdq.push_back(32'h0);
		bus(1'b0, ad(0, 1'b0), 32'h0);
		bus(1'b1, ad(0, 1'b0), 32'h0);
		hsize <= 3'h2;
		rd_reg(0, 1'b0);
		// random traffic, random per-pin modes
		for (int i = 0; i < 60; i++) begin
			r = rnd();
			mode <= {rnd(), rnd()};
			wr_reg(r[1:0], r[8], rnd());
			rd_reg(r[1:0], 1'b0);
			chk_pads();
		end
		// the alias gets through even with every bit protected
		for (int p = 0; p < 4; p++) begin
			wr_reg(p, 1'b1, 32'hffff_ffff);
			for (int n = 0; n < 8; n++) begin
				r = rnd();
				@(posedge hclk);
				al_wr <= 1'b1;
				al_port <= p[1:0];
				al_pin <= n[2:0];
				al_val <= r[0];
				if (gom_pkg::IMPL_PINS[p][n]) ov[p][n] = r[0];
				@(posedge hclk);
				al_wr <= 1'b0;
			end
			rd_reg(p, 1'b0);
		end
		chk_pads();
		give_verdict();
	end
endmodule
